// ### design/icc_mem.sv
// Simple dual-port RAM with registered read data
`timescale 1ns/10ps
`default_nettype none
module icc_mem #(
    parameter int W  = 32,
    parameter int AW = 9
) (
    input  wire logic          clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);
    logic [W-1:0] mem [2**AW];

    // No reset on the array; tags are cleared by the controller instead
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // icc_mem
`default_nettype wire

// ### design/icc_params.svh
// Constants for the instruction cache controller
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH
`define ICC_CLK_MHZ          20
`define ICC_CLEAR_CYCLES     450
`define ICC_CM2R_CYCLES      3
`define ICC_CLAT_CYCLES      4
`define ICC_MON_WINDOW_US    10000
`define ICC_MON_MAX_CYCLES   (`ICC_MON_WINDOW_US * `ICC_CLK_MHZ)
`define ICC_MON_W            18
`define ICC_LFSR_SEED        8'h01
`define ICC_PHYS_LINE_BYTES  25'h8
`define ICC_SET_LSB          3
`define ICC_SET_MSB          8
`define ICC_BANK_LSB         9
`define ICC_BANK_MSB         10
`define ICC_TAG_ADDR_MSB     22
`define ICC_TAG_ADDR_LSB     3
`endif

// ### design/icc_pkg.sv
// Types for the instruction cache controller
`include "icc_params.svh"
package icc_pkg;
    typedef enum logic [6:0] {
        ST_CLEAR = 7'h01,
        ST_IDLE  = 7'h02,
        ST_LOOK  = 7'h04,
        ST_HITD  = 7'h08,
        ST_REQW  = 7'h10,
        ST_FILL  = 7'h20,
        ST_CLAT  = 7'h40
    } icc_state_e;

    typedef enum logic [1:0] {
        ASSOC_1WAY = 2'h0,
        ASSOC_2WAY = 2'h1,
        ASSOC_4WAY = 2'h2
    } icc_assoc_e;

    // Tag word: top bit zero, line address 22:2, valid size code
    typedef struct packed {
        logic        zero;
        logic [20:0] line_addr;
        logic [1:0]  valid;
    } icc_tag_s;

    typedef struct packed {
        icc_state_e             st;
        logic [8:0]             clr_cnt;
        logic [24:0]            req_addr;
        logic [24:0]            fill_base;
        logic [1:0]             fill_lsz;
        logic [1:0]             fill_bank;
        logic [2:0]             cnt;
        logic [31:0]            data;
        logic                   valid;
        logic                   mem_req;
        logic [7:0]             lfsr;
        logic [`ICC_MON_W-1:0]  int_cnt;
        logic [`ICC_MON_W-1:0]  hit_w;
        logic [`ICC_MON_W-1:0]  miss_w;
        logic [`ICC_MON_W-1:0]  hit_out;
        logic [`ICC_MON_W-1:0]  miss_out;
        logic                   irq;
    } icc_ctrl_s;
endpackage

// ### design/icc_top.sv
// Instruction cache controller with tag clearing and miss-rate monitor
`timescale 1ns/10ps
`default_nettype none
`include "icc_params.svh"
module icc_top import icc_pkg::*; (
    input  wire logic                   MCLK,
    input  wire logic                   RST,
    input  wire logic                   SOFT_RESET_INPUT,
    input  wire logic [1:0]             ASSOCIATIVITY_SETTING,
    input  wire logic [1:0]             LINE_SIZE_SETTING,
    input  wire logic                   FETCH_REQ,
    input  wire logic [24:0]            FETCH_ADDR,
    output logic                        FETCH_READY,
    output logic                        FETCH_VALID,
    output logic      [31:0]            FETCH_DATA,
    output logic                        MEM_REQ,
    output logic      [24:0]            MEM_ADDR,
    output logic      [3:0]             MEM_WORDS,
    input  wire logic                   MEM_RVALID,
    input  wire logic [31:0]            MEM_RDATA,
    input  wire logic                   ACTIVE_MODE,
    input  wire logic [`ICC_MON_W-1:0]  MONITOR_INTERVAL_LENGTH,
    input  wire logic [`ICC_MON_W-1:0]  MONITOR_MISS_THRESHOLD,
    output logic      [`ICC_MON_W-1:0]  MONITOR_HIT_COUNT,
    output logic      [`ICC_MON_W-1:0]  MONITOR_MISS_COUNT,
    output logic                        MONITOR_IRQ,
    input  wire logic                   MONITOR_IRQ_ACK
);
    localparam icc_ctrl_s CTRL_RST = '{st: ST_CLEAR, lfsr: `ICC_LFSR_SEED, default: '0};

    icc_ctrl_s  s_q;
    icc_ctrl_s  s_d;
    icc_tag_s   tag_rd [4];
    icc_tag_s   tag_wd;
    logic [3:0] tag_we;
    logic [5:0] tag_wa;
    logic [3:0] cand;
    logic [3:0] hit_m;
    logic [3:0] empty_m;
    logic [1:0] hit_bank;
    logic [31:0] dat_rd;
    logic [24:0] fill_word;
    logic        look_hit;
    logic        look_miss;
    logic        hit_ev;
    logic        miss_ev;
    logic        data_we;
    logic        expire;

    // Banks that may hold the address under the current associativity
    function automatic logic [3:0] cand_mask(input logic [1:0] asc, input logic [24:0] a);
        if (asc == ASSOC_1WAY) begin
            return 4'h1 << a[`ICC_BANK_MSB:`ICC_BANK_LSB];
        end else if (asc == ASSOC_2WAY) begin
            return a[`ICC_BANK_LSB] ? 4'ha : 4'h5;
        end
        return 4'hf;
    endfunction

    // Physical bank for a given way
    function automatic logic [1:0] way_bank(input logic [1:0] asc, input logic [24:0] a, input logic [1:0] way);
        if (asc == ASSOC_1WAY) begin
            return a[`ICC_BANK_MSB:`ICC_BANK_LSB];
        end else if (asc == ASSOC_2WAY) begin
            return {way[0], a[`ICC_BANK_LSB]};
        end
        return way;
    endfunction

    // Lowest set bit, which is also the lowest way among candidates
    function automatic logic [1:0] first_bank(input logic [3:0] m);
        return m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
    endfunction

    // Reserved line size code is treated as 32 bytes
    function automatic logic [1:0] norm_lsz(input logic [1:0] v);
        return (v == 2'h3) ? 2'h2 : v;
    endfunction

    function automatic logic [3:0] line_words(input logic [1:0] lsz);
        return 4'h2 << lsz;
    endfunction

    for (genvar b = 0; b < 4; b++) begin : g_tag
        icc_mem #(.W(24), .AW(6)) u_tag (
            .clk     (MCLK),
            .wr_en   (tag_we[b]),
            .wr_addr (tag_wa),
            .wr_data (tag_wd),
            .rd_addr (FETCH_ADDR[`ICC_SET_MSB:`ICC_SET_LSB]),
            .rd_data (tag_rd[b])
        );
    end

    // Data store: bank, set, word within 8-byte physical line
    icc_mem #(.W(32), .AW(9)) u_data (
        .clk     (MCLK),
        .wr_en   (data_we),
        .wr_addr ({s_q.fill_bank, fill_word[`ICC_SET_MSB:2]}),
        .wr_data (MEM_RDATA),
        .rd_addr ({hit_bank, s_q.req_addr[`ICC_SET_MSB:2]}),
        .rd_data (dat_rd)
    );

    // Lookup against the four tags read in the accept cycle
    always_comb begin
        cand = cand_mask(ASSOCIATIVITY_SETTING, s_q.req_addr);
        for (int b = 0; b < 4; b++) begin
            hit_m[b]   = cand[b] && (tag_rd[b].valid != 2'h0)
                         && (tag_rd[b].line_addr[20:1] == s_q.req_addr[`ICC_TAG_ADDR_MSB:`ICC_TAG_ADDR_LSB]);
            empty_m[b] = cand[b] && (tag_rd[b].valid == 2'h0);
        end
        hit_bank  = first_bank(hit_m);
        look_hit  = (s_q.st == ST_LOOK) && (hit_m != 4'h0);
        look_miss = (s_q.st == ST_LOOK) && (hit_m == 4'h0);
    end

    // Tag and data writes: clearing writes zero to every bank
    always_comb begin
        fill_word = s_q.fill_base + 25'({s_q.cnt, 2'b00});
        data_we   = (s_q.st == ST_FILL) && MEM_RVALID;
        if (s_q.st == ST_CLEAR) begin
            tag_we = 4'hf;
            tag_wa = s_q.clr_cnt[5:0];
            tag_wd = '0;
        end else begin
            // one tag per 8-byte physical line
            tag_we = (data_we && fill_word[2]) ? (4'h1 << s_q.fill_bank) : 4'h0;
            tag_wa = fill_word[`ICC_SET_MSB:`ICC_SET_LSB];
            tag_wd = '{zero: 1'b0, line_addr: {fill_word[`ICC_TAG_ADDR_MSB:`ICC_TAG_ADDR_LSB], 1'b0},
                       valid: s_q.fill_lsz + 2'h1};
        end
    end

    // Controller and monitor next state
    always_comb begin
        s_d      = s_q;
        s_d.valid = 1'b0;
        s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
        unique case (s_q.st)
            ST_CLEAR: begin
                s_d.clr_cnt = s_q.clr_cnt + 9'h1;
                if (s_q.clr_cnt == 9'(`ICC_CLEAR_CYCLES - 1)) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (FETCH_REQ) begin
                    s_d.req_addr = FETCH_ADDR;
                    s_d.st       = ST_LOOK;
                end
            end
            ST_LOOK: begin
                if (look_hit) begin
                    s_d.st = ST_HITD;
                end else begin
                    // settings sampled live at each miss
                    s_d.fill_lsz  = norm_lsz(LINE_SIZE_SETTING);
                    s_d.fill_base = s_q.req_addr
                                    & ~((`ICC_PHYS_LINE_BYTES << norm_lsz(LINE_SIZE_SETTING)) - 25'h1);
                    s_d.fill_bank = (empty_m != 4'h0) ? first_bank(empty_m)
                                    : way_bank(ASSOCIATIVITY_SETTING, s_q.req_addr, s_q.lfsr[1:0]);
                    s_d.cnt       = 3'h0;
                    s_d.st        = ST_REQW;
                end
            end
            ST_HITD: begin
                s_d.data  = dat_rd;
                s_d.valid = 1'b1;
                s_d.st    = ST_IDLE;
            end
            ST_REQW: begin
                if (s_q.cnt == 3'(`ICC_CM2R_CYCLES - 2)) begin
                    s_d.cnt     = 3'h0;
                    s_d.mem_req = 1'b1;
                    s_d.st      = ST_FILL;
                end else begin
                    s_d.cnt = s_q.cnt + 3'h1;
                end
            end
            ST_FILL: begin
                if (MEM_RVALID) begin
                    if (fill_word[22:2] == s_q.req_addr[22:2]) begin
                        s_d.data = MEM_RDATA; // Critical word kept for delivery
                    end
                    if ({1'b0, s_q.cnt} == line_words(s_q.fill_lsz) - 4'h1) begin
                        s_d.cnt     = 3'h0;
                        s_d.mem_req = 1'b0;
                        s_d.st      = ST_CLAT;
                    end else begin
                        s_d.cnt = s_q.cnt + 3'h1;
                    end
                end
            end
            ST_CLAT: begin
                if (s_q.cnt == 3'(`ICC_CLAT_CYCLES - 2)) begin
                    s_d.valid = 1'b1;
                    s_d.cnt   = 3'h0;
                    s_d.st    = ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt + 3'h1;
                end
            end
            default: begin
                s_d.st = ST_CLEAR;
            end
        endcase
        if (SOFT_RESET_INPUT) begin
            s_d.st      = ST_CLEAR;
            s_d.clr_cnt = 9'h0;
            s_d.cnt     = 3'h0;
            s_d.valid   = 1'b0;
            s_d.mem_req = 1'b0;
        end

        if (expire) begin
            s_d.int_cnt  = '0;
            s_d.hit_out  = s_q.hit_w + `ICC_MON_W'(hit_ev);
            s_d.miss_out = s_q.miss_w + `ICC_MON_W'(miss_ev);
            s_d.hit_w    = '0;
            s_d.miss_w   = '0;
        end else if (ACTIVE_MODE && (MONITOR_INTERVAL_LENGTH != '0)) begin
            s_d.int_cnt = s_q.int_cnt + `ICC_MON_W'(1);
            s_d.hit_w   = s_q.hit_w + `ICC_MON_W'(hit_ev);
            s_d.miss_w  = s_q.miss_w + `ICC_MON_W'(miss_ev);
        end
        // held until acknowledged; a new event beats the ack
        if (MONITOR_IRQ_ACK) begin
            s_d.irq = 1'b0;
        end
        if (miss_ev && (MONITOR_MISS_THRESHOLD != '0)
            && (s_q.miss_w + `ICC_MON_W'(1) == MONITOR_MISS_THRESHOLD)) begin
            s_d.irq = 1'b1;
        end
    end

    assign hit_ev  = look_hit && ACTIVE_MODE && (MONITOR_INTERVAL_LENGTH != '0);
    assign miss_ev = look_miss && ACTIVE_MODE && (MONITOR_INTERVAL_LENGTH != '0);
    assign expire  = ACTIVE_MODE && (MONITOR_INTERVAL_LENGTH != '0)
                     && (s_q.int_cnt >= MONITOR_INTERVAL_LENGTH - `ICC_MON_W'(1));

    // hard reset starts the clearing pass
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            s_q <= CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign FETCH_READY        = (s_q.st == ST_IDLE);
    assign FETCH_VALID        = s_q.valid;
    assign FETCH_DATA         = s_q.data;
    assign MEM_REQ            = s_q.mem_req;
    assign MEM_ADDR           = s_q.fill_base;
    assign MEM_WORDS          = line_words(s_q.fill_lsz);
    assign MONITOR_HIT_COUNT  = s_q.hit_out;
    assign MONITOR_MISS_COUNT = s_q.miss_out;
    assign MONITOR_IRQ        = s_q.irq;

    // Helper for the fill-order check
    logic [3:0] empty_q;
    always_ff @(posedge MCLK) begin
        empty_q <= empty_m;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST || SOFT_RESET_INPUT);

    sequence s_req_wait;
        !MEM_REQ [*3] ##1 MEM_REQ;
    endsequence
    sequence s_deliver;
        !FETCH_VALID [*4] ##1 FETCH_VALID;
    endsequence

    chk_miss_req_delay: assert property (look_miss |-> s_req_wait)
        else $error("memory request not raised 3 cycles after miss");
    chk_fill_deliver: assert property (
        (s_q.st == ST_FILL) && MEM_RVALID && ({1'b0, s_q.cnt} == MEM_WORDS - 4'h1) |-> s_deliver)
        else $error("fetch data not delivered 4 cycles after last fill word");
    chk_clear_length: assert property (
        (s_q.st == ST_IDLE) && ($past(s_q.st) == ST_CLEAR) |-> $past(s_q.clr_cnt) == 9'd449)
        else $error("tag clearing did not last 450 cycles");
    chk_clear_stall: assert property ((s_q.st == ST_CLEAR) |-> !FETCH_READY && !FETCH_VALID)
        else $error("fetch accepted during tag clearing");
    chk_empty_first: assert property (look_miss && (empty_m != 4'h0) |=> empty_q[s_q.fill_bank]
        && ((empty_q & ((4'h1 << s_q.fill_bank) - 4'h1)) == 4'h0))
        else $error("occupied way filled while an empty way existed");
    chk_victim_lfsr: assert property (
        look_miss && (empty_m == 4'h0) && (ASSOCIATIVITY_SETTING == ASSOC_4WAY)
        |=> s_q.fill_bank == $past(s_q.lfsr[1:0]))
        else $error("victim way not taken from the LFSR");
    chk_tag_format: assert property ((tag_we != 4'h0) && (s_q.st == ST_FILL)
        |-> !tag_wd.zero && (tag_wd.valid == s_q.fill_lsz + 2'h1) && !tag_wd.line_addr[0])
        else $error("tag word written with wrong format");
    chk_sleep_hold: assert property (!ACTIVE_MODE |=> $stable(s_q.hit_w) && $stable(s_q.miss_w))
        else $error("monitor counted during sleep");
    chk_irq_threshold: assert property (miss_ev && (MONITOR_MISS_THRESHOLD != '0)
        && (s_q.miss_w + `ICC_MON_W'(1) == MONITOR_MISS_THRESHOLD) |=> MONITOR_IRQ)
        else $error("threshold reached without interrupt");
    chk_irq_hold: assert property (MONITOR_IRQ && !MONITOR_IRQ_ACK |=> MONITOR_IRQ)
        else $error("interrupt dropped without acknowledge");
    chk_interval_end: assert property (expire |=> (s_q.hit_w == '0) && (s_q.miss_w == '0)
        && (MONITOR_MISS_COUNT == $past(s_q.miss_w) + `ICC_MON_W'($past(miss_ev))))
        else $error("interval expiry did not publish and restart counts");
endmodule // icc_top
`default_nettype wire

// ### tb/icc_far_mem.sv
// Far-side code memory model with flash or OTP burst timing
`timescale 1ns/10ps
`default_nettype none
module icc_far_mem #(
    parameter int T_CMD  = 2,
    parameter int T_ADDR = 8,
    parameter int T_DUM  = 4,
    parameter int T_PIPE = 1
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        otp_mode,
    input  wire logic        mem_req,
    input  wire logic [24:0] mem_addr,
    input  wire logic [3:0]  mem_words,
    output logic             rvalid,
    output logic      [31:0] rdata
);
    logic        busy_q;
    logic        done_q;
    logic [24:0] addr_q;
    logic [3:0]  left_q;
    int          wait_q;

    // Burst engine; idle data toggles so a stale word never passes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            addr_q <= 25'h0;
            left_q <= 4'h0;
            wait_q <= 0;
            rvalid <= 1'b0;
            rdata  <= 32'h0;
        end else begin
            rvalid <= 1'b0;
            rdata  <= ~rdata;
            if (!mem_req) begin
                // Aborted fill simply drops the burst
                busy_q <= 1'b0;
                done_q <= 1'b0;
            end else if (!busy_q && !done_q) begin
                busy_q <= 1'b1;
                addr_q <= mem_addr;
                left_q <= mem_words;
                wait_q <= otp_mode ? 2 : 2 + T_CMD + T_ADDR + T_DUM + T_PIPE;
            end else if (busy_q && wait_q > 0) begin
                wait_q <= wait_q - 1;
            end else if (busy_q) begin
                rvalid <= 1'b1;
                rdata  <= {addr_q[24:2], 9'h0a5};
                addr_q <= addr_q + 25'h4;
                left_q <= left_q - 4'h1;
                wait_q <= otp_mode ? 0 : 7;
                done_q <= left_q == 4'h1;
                busy_q <= left_q != 4'h1;
            end
        end
    end
endmodule // icc_far_mem
`default_nettype wire

// ### tb/icc_top_test.sv
// Self-checking bench for the instruction cache controller
`timescale 1ns/10ps
`default_nettype none
`include "icc_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module icc_top_test;
    logic        clk = 0, rst = 1, srst = 0, req = 0, otp = 1, act = 0, ack = 0;
    logic [1:0]  assoc = 2'h2, lsz = 2'h1;
    logic [24:0] addr = 25'h0;
    logic [`ICC_MON_W-1:0] ilen = '0, thr = '0;
    wire logic   ready, fvalid, mreq, rvalid, irq;
    wire logic [31:0] fdata, rdata;
    wire logic [24:0] maddr;
    wire logic [3:0]  mwords;
    wire logic [`ICC_MON_W-1:0] hits, misses;
    int          failures = 0, checks_done = 0, x;

    // Free-running 20 MHz clock
    always #25 clk = ~clk;

    icc_top u_icc_top (.MCLK(clk), .RST(rst), .SOFT_RESET_INPUT(srst), .ASSOCIATIVITY_SETTING(assoc),
        .LINE_SIZE_SETTING(lsz), .FETCH_REQ(req), .FETCH_ADDR(addr), .FETCH_READY(ready),
        .FETCH_VALID(fvalid), .FETCH_DATA(fdata), .MEM_REQ(mreq), .MEM_ADDR(maddr), .MEM_WORDS(mwords),
        .MEM_RVALID(rvalid), .MEM_RDATA(rdata), .ACTIVE_MODE(act), .MONITOR_INTERVAL_LENGTH(ilen),
        .MONITOR_MISS_THRESHOLD(thr), .MONITOR_HIT_COUNT(hits), .MONITOR_MISS_COUNT(misses),
        .MONITOR_IRQ(irq), .MONITOR_IRQ_ACK(ack));
    icc_far_mem u_icc_far_mem (.clk(clk), .rst(rst), .otp_mode(otp), .mem_req(mreq), .mem_addr(maddr),
        .mem_words(mwords), .rvalid(rvalid), .rdata(rdata));

    // Verdict and the single end of the run
    task automatic close_out;
        $display("Counts: %0d checks, %0d failures", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tmo;
        failures++;
        $display("Error t=%0t wait bound %h exp %h", $time, 1'b0, 1'b1);
        close_out();
    endtask

    // Bounded wait for the idle state, counting cycles
    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 600) tmo();
        end
    endtask

    // One fetch; exp_miss 2 means either outcome is fine
    task automatic fetch(input logic [24:0] a, input int exp_miss, output int miss);
        int n, fr, lw, w, bytes;
        wait_ready(w);
        bytes = 8 << (lsz > 2'h2 ? 2 : int'(lsz));
        addr = a;
        req = 1;
        @(negedge clk);
        req = 0;
        n = 1;
        fr = 0;
        lw = 0;
        while (fvalid !== 1'b1) begin
            if (mreq === 1'b1 && fr == 0) begin
                fr = n;
                `CHK(maddr, a & ~(bytes - 1))
                `CHK(mwords, 4'(bytes / 4))
            end
            if (rvalid === 1'b1) lw = n;
            @(negedge clk);
            n++;
            if (n > 400) tmo();
        end
        miss = int'(fr != 0);
        if (exp_miss < 2) `CHK(miss, exp_miss)
        if (miss != 0) begin
            `CHK(fr, 4)
            `CHK(n, lw + 4)
        end else `CHK(n, 3)
        `CHK(fdata, {a[24:2], 9'h0a5})
    endtask

    task automatic soft_clear;
        int n;
        srst = 1;
        @(negedge clk);
        srst = 0;
        wait_ready(n);
        `CHK(n, 450)
    endtask

    // Clearing after hard reset, fetch held pending meanwhile
    task automatic t_reset;
        int n;
        addr = 25'h40;
        req = 1;
        repeat (6) @(negedge clk);
        `CHK({ready, fvalid, mreq, irq, mwords, hits}, 26'h0080000)
        rst = 0;
        wait_ready(n);
        `CHK(n, 450)
        @(negedge clk);
        req = 0;
        n = 0;
        while (fvalid !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 100) tmo();
        end
        `CHK(fdata, {23'h10, 9'h0a5})
        $display("reset test done");
    endtask

    // Miss and hit timing, line sizes, flash and OTP backing
    task automatic t_latency;
        fetch(25'h100, 1, x);
        fetch(25'h104, 0, x);
        fetch(25'h10c, 0, x);
        fetch(25'h110, 1, x);
        otp = 0;
        fetch(25'h300, 1, x);
        otp = 1;
        lsz = 2'h0;
        fetch(25'h408, 1, x);
        fetch(25'h40c, 0, x);
        fetch(25'h400, 1, x);
        lsz = 2'h1;
        fetch(25'h500, 1, x);
        lsz = 2'h2;
        fetch(25'h50c, 0, x);
        fetch(25'h510, 1, x);
        fetch(25'h508, 0, x);
        $display("latency test done");
    endtask

    // Every associativity: fill ways, hit them all, then replace
    task automatic t_assoc;
        int ways;
        lsz = 2'h1;
        for (int m = 0; m < 3; m++) begin
            assoc = 2'(m);
            soft_clear();
            ways = 1 << m;
            for (int i = 0; i < ways; i++) fetch(25'h600 + 25'(i * 'h800), 1, x);
            for (int i = 0; i < ways; i++) fetch(25'h600 + 25'(i * 'h800), 0, x);
            fetch(25'h600 + 25'(ways * 'h800), 1, x);
            fetch(25'h600 + 25'(ways * 'h800), 0, x);
            if (m == 0) fetch(25'h600, 1, x);
        end
        assoc = 2'h2;
        $display("associativity test done");
    endtask

    // Miss monitor: threshold, sleep freeze, publish, ack, restart
    task automatic t_monitor;
        int n;
        ilen = 'd300;
        thr = 'd2;
        soft_clear();
        act = 1;
        fetch(25'h2000, 1, x);
        `CHK(irq, 1'b0)
        fetch(25'h2004, 0, x);
        fetch(25'h3000, 1, x);
        `CHK(irq, 1'b1)
        act = 0;
        // A hit while asleep must not reach the counts
        fetch(25'h2004, 0, x);
        repeat (400) @(negedge clk);
        `CHK(misses, 18'h0)
        act = 1;
        n = 0;
        while (misses === 18'h0) begin
            @(negedge clk);
            n++;
            if (n > 400) tmo();
        end
        `CHK({hits, misses}, {18'h1, 18'h2})
        ack = 1;
        @(negedge clk);
        ack = 0;
        @(negedge clk);
        `CHK(irq, 1'b0)
        repeat (310) @(negedge clk);
        `CHK({hits, misses}, 36'h0)
        $display("monitor test done");
    endtask

    initial begin
        t_reset();
        t_latency();
        t_assoc();
        t_monitor();
        close_out();
    end
endmodule // icc_top_test
`default_nettype wire
